//--- pkg/ovw_regs.svh
// register offsets, retry field codes and reset values of the over-voltage warning response
`ifndef OVW_REGS_SVH
`define OVW_REGS_SVH

`define OVW_CMD_CODE      8'hc4
`define OVW_RESET_VALUE   8'h00
`define OVW_RETRY_NONE    3'h0
`define OVW_RETRY_FOREVER 3'h7
`define OVW_UNIT_W        16

`endif

//--- pkg/ovw_pkg.sv
// types shared by the over-voltage warning response sequencer
package ovw_pkg;

  typedef enum logic [1:0] {
    RESP_IGNORE   = 2'b00,
    RESP_CONTINUE = 2'b01,
    RESP_RETRY    = 2'b10,
    RESP_LATCH    = 2'b11
  } resp_e;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_DELAY   = 3'b001,
    ST_WAIT    = 3'b010,
    ST_LATCHED = 3'b011,
    ST_OFF     = 3'b100
  } state_e;

  // layout of the response byte: [7:6] response, [5:3] retries, [2:0] delay exponent
  typedef struct packed {
    resp_e      resp;
    logic [2:0] retries;
    logic [2:0] delay_exp;
  } cfg_s;

  typedef struct packed {
    logic status_bit;
    logic clear_faults;
  } clear_s;

endpackage

//--- rtl/ovw_delay_timer.sv
// interval timer: unit_cycles clock cycles per unit, 2^exp units per interval
`timescale 1ns/1ps
module ovw_delay_timer #(
  parameter int UNIT_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              run,
  input  wire logic              start,
  input  wire logic [2:0]        delay_exp,
  input  wire logic [UNIT_W-1:0] unit_cycles,
  output logic                   done
);

  logic [UNIT_W-1:0] cyc;
  logic [7:0]        units;
  logic [UNIT_W-1:0] last_cyc;
  logic [7:0]        last_unit;

  // a unit length of zero is served as one cycle rather than never ending
  assign last_cyc  = (unit_cycles == '0) ? '0 : unit_cycles - UNIT_W'(1);
  assign last_unit = 8'((9'h001 << delay_exp) - 9'h001);
  assign done      = run && (cyc == last_cyc) && (units == last_unit);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cyc   <= '0;
      units <= 8'h00;
    end else if (!run || start) begin
      cyc   <= '0;
      units <= 8'h00;
    end else if (cyc >= last_cyc) begin
      cyc   <= '0;
      units <= units + 8'h01;
    end else begin
      cyc <= cyc + UNIT_W'(1);
    end
  end

endmodule

//--- rtl/ovw_response.sv
// input over-voltage warning fault response sequencer
`include "ovw_regs.svh"
`timescale 1ns/1ps
// ==========================================================================
// Operation
// - response code zero keeps the output regulating with no shutdown or restart.
// - response code one keeps running for the delay, then follows the retry field if the warning persists.
// - response code two disables the output at once and follows the retry field.
// - response code three disables the output and keeps it off until the fault is cleared.
// - a latched fault clears by status bit clear, clear faults, reset or off-then-on.
// - retry field zero makes no restart attempt and keeps the output off until cleared.
// - retry values one to six allow that many attempts, then latch off.
// - attempt starts are spaced by the delay multiplier times the delay unit.
// - retry value seven retries without limit until commanded off or another fault.
// - the delay field n selects 2^n delay units.
// - the delay unit length comes from a separate configuration input.
// - the setting is one byte read and written at command code c4.
module ovw_response
  import ovw_pkg::*;
#(
  parameter int UNIT_W = `OVW_UNIT_W
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [7:0]        cmd_code,
  input  wire logic [7:0]        cmd_wdata,
  output logic                   cmd_ack,
  output logic [7:0]             cmd_rdata,
  input  wire logic              warn_in,
  input  wire logic [UNIT_W-1:0] unit_cycles,
  input  wire logic              clear_status_bit,
  input  wire logic              clear_faults,
  input  wire logic              output_on_cmd,
  input  wire logic              other_fault,
  output logic                   output_enable,
  output logic                   fault_latched,
  output logic [2:0]             attempts
);

  // ========================================================================
  // elaboration check
  if (UNIT_W < 1 || UNIT_W > 24) begin : g_bad_width
    $error("UNIT_W must lie between 1 and 24");
  end

  // ========================================================================
  // setting register
  logic   [7:0] setting;
  cfg_s         cfg;
  clear_s       clr;
  logic         setting_write;
  logic         clear_any;

  assign cfg           = cfg_s'(setting);
  assign clr           = '{status_bit: clear_status_bit, clear_faults: clear_faults};
  assign clear_any     = clr.status_bit | clr.clear_faults;
  assign cmd_ack       = cmd_valid && (cmd_code == `OVW_CMD_CODE);
  assign setting_write = cmd_ack && cmd_write;
  assign cmd_rdata     = setting;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      setting <= `OVW_RESET_VALUE;
    end else if (setting_write) begin
      setting <= cmd_wdata;
    end
  end

  // ========================================================================
  // sequencer
  state_e state;
  state_e next_state;
  logic   timer_start;
  logic   timer_done;
  logic   timer_run;
  logic   attempt_inc;
  logic   attempt_clr;

  assign timer_run = (state == ST_DELAY) || (state == ST_WAIT);

  ovw_delay_timer #(
    .UNIT_W (UNIT_W)
  ) u_timer (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .run         (timer_run),
    .start       (timer_start),
    .delay_exp   (cfg.delay_exp),
    .unit_cycles (unit_cycles),
    .done        (timer_done)
  );

  always_comb begin
    next_state  = state;
    timer_start = 1'b0;
    attempt_inc = 1'b0;
    attempt_clr = 1'b0;
    if (!output_on_cmd) begin
      next_state  = ST_OFF;
      attempt_clr = 1'b1;
    end else begin
      case (state)
        ST_RUN: begin
          if (warn_in) begin
            case (cfg.resp)
              RESP_IGNORE: next_state = ST_RUN;
              RESP_CONTINUE: begin
                next_state  = ST_DELAY;
                timer_start = 1'b1;
              end
              RESP_RETRY: begin
                if (cfg.retries == `OVW_RETRY_NONE) begin
                  next_state = ST_LATCHED;
                end else begin
                  next_state  = ST_WAIT;
                  timer_start = 1'b1;
                end
              end
              default: next_state = ST_LATCHED;
            endcase
          end
        end
        ST_DELAY: begin
          if (!warn_in || clear_any) begin
            next_state = ST_RUN;
          end else if (timer_done) begin
            if (cfg.retries == `OVW_RETRY_NONE) begin
              next_state = ST_LATCHED;
            end else begin
              next_state  = ST_WAIT;
              timer_start = 1'b1;
            end
          end
        end
        ST_WAIT: begin
          if (clear_any) begin
            next_state  = ST_RUN;
            attempt_clr = 1'b1;
          end else if (other_fault) begin
            next_state = ST_LATCHED;
          end else if (timer_done) begin
            // the attempt succeeds only if the warning has gone by its start
            if (!warn_in) begin
              next_state  = ST_RUN;
              attempt_clr = 1'b1;
            end else if (cfg.retries == `OVW_RETRY_FOREVER) begin
              timer_start = 1'b1;
            end else if (attempts + 3'h1 >= cfg.retries) begin
              next_state = ST_LATCHED;
            end else begin
              attempt_inc = 1'b1;
              timer_start = 1'b1;
            end
          end
        end
        ST_LATCHED: begin
          if (clear_any) begin
            next_state  = ST_RUN;
            attempt_clr = 1'b1;
          end
        end
        ST_OFF: begin
          next_state  = ST_RUN;
          attempt_clr = 1'b1;
        end
        default: next_state = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      attempts <= 3'h0;
    end else if (attempt_clr) begin
      attempts <= 3'h0;
    end else if (attempt_inc) begin
      attempts <= attempts + 3'h1;
    end
  end

  // output follows the next state so a disabling response acts at the next edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      output_enable <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      output_enable <= (next_state == ST_RUN) || (next_state == ST_DELAY);
      fault_latched <= (next_state == ST_LATCHED);
    end
  end

  // ========================================================================
  // checks
  logic [31:0] ivl_cnt;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ivl_cnt <= 32'h0;
    end else if (timer_start || !timer_run) begin
      ivl_cnt <= 32'h0;
    end else begin
      ivl_cnt <= ivl_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  AST_IGNORE_RUNS: assert property (
    state == ST_RUN && output_on_cmd && cfg.resp == RESP_IGNORE |=> output_enable)
    else $error("ignore response disturbed the output");

  AST_CONTINUE_ON: assert property (
    state == ST_RUN && output_on_cmd && warn_in && cfg.resp == RESP_CONTINUE
    |=> state == ST_DELAY && output_enable)
    else $error("continue response did not keep running");

  AST_RETRY_OFF: assert property (
    state == ST_RUN && output_on_cmd && warn_in && cfg.resp == RESP_RETRY
    |=> !output_enable)
    else $error("retry response left the output on");

  AST_LATCH_HOLDS: assert property (
    state == ST_LATCHED && output_on_cmd && !clear_any
    |=> state == ST_LATCHED && !output_enable && fault_latched)
    else $error("latched fault did not hold");

  AST_CLEAR_RELEASES: assert property (
    state == ST_LATCHED && output_on_cmd && clear_any |=> state == ST_RUN && output_enable)
    else $error("clear did not release latched fault");

  AST_NO_RETRY: assert property (
    state == ST_RUN && output_on_cmd && warn_in && cfg.resp == RESP_RETRY
    && cfg.retries == `OVW_RETRY_NONE |=> state == ST_LATCHED)
    else $error("zero retries did not latch");

  AST_RETRY_LIMIT: assert property (
    state == ST_WAIT && timer_done && warn_in && output_on_cmd && !clear_any
    && !other_fault && cfg.retries != `OVW_RETRY_FOREVER && attempts + 3'h1 == cfg.retries
    |=> state == ST_LATCHED)
    else $error("retry limit not honoured");

  AST_SPACING: assert property (
    timer_done && unit_cycles != '0 && $stable(unit_cycles) && $stable(cfg.delay_exp)
    |-> ivl_cnt == (32'(unit_cycles) << cfg.delay_exp) - 32'h1)
    else $error("interval length wrong");

  AST_FOREVER: assert property (
    state == ST_WAIT && timer_done && warn_in && output_on_cmd && !clear_any
    && !other_fault && cfg.retries == `OVW_RETRY_FOREVER |=> state == ST_WAIT)
    else $error("unlimited retry stopped");

  AST_OFF_RESETS: assert property (
    !output_on_cmd |=> attempts == 3'h0 && !output_enable && !timer_done)
    else $error("off command did not reset the sequencer");

  AST_REG_RW: assert property (
    setting_write |=> cmd_rdata == $past(cmd_wdata))
    else $error("setting write not read back");

  COV_LATCHED: cover property (state == ST_WAIT ##1 state == ST_LATCHED);
  COV_RETRY_OK: cover property (state == ST_WAIT ##1 state == ST_RUN);
  COV_DELAY_EXPIRE: cover property (state == ST_DELAY ##1 state == ST_WAIT);
  COV_FOREVER: cover property (state == ST_WAIT && timer_done && timer_start);

endmodule

//--- sim/ovw_host.sv
// management bus host model for the response setting
`timescale 1ns/1ps
// ==========
// host
module ovw_host (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic       wr,
  input  wire logic [7:0] code,
  input  wire logic [7:0] wdata,
  input  wire logic       cmd_ack,
  input  wire logic [7:0] cmd_rdata,
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata,
  output logic            done,
  output logic            acked,
  output logic [7:0]      rbyte
);
  // one byte per transfer, judged at the edge that ends it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_valid <= 1'b0;
      cmd_write <= 1'b0;
      cmd_code  <= 8'h00;
      cmd_wdata <= 8'h00;
      done      <= 1'b0;
      acked     <= 1'b0;
      rbyte     <= 8'h00;
    end else begin
      done <= 1'b0;
      if (cmd_valid) begin
        cmd_valid <= 1'b0;
        done      <= 1'b1;
        acked     <= cmd_ack;
        rbyte     <= cmd_rdata;
        // released lines flip so a stale value is never mistaken for a live one
        cmd_code  <= ~cmd_code;
        cmd_wdata <= ~cmd_wdata;
      end else if (go) begin
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code  <= code;
        cmd_wdata <= wdata;
      end
    end
  end
endmodule

//--- sim/ovw_response_tb.sv
// self-checking bench of the over-voltage warning response sequencer
`timescale 1ns/1ps
// ==========
// bench
module ovw_response_tb;
  import ovw_pkg::*;
  logic        sys_clk, resetn, go, wr, warn_in, clear_status_bit, clear_faults;
  logic        output_on_cmd, other_fault, cmd_valid, cmd_write, cmd_ack, done, acked;
  logic        output_enable, fault_latched;
  logic [7:0]  code, wdata, cmd_code, cmd_wdata, cmd_rdata, rbyte;
  logic [2:0]  attempts;
  logic [15:0] unit_cycles;
  int          error_cnt, tests_run;

  ovw_host ovw_host_i (.sys_clk(sys_clk), .resetn(resetn), .go(go), .wr(wr), .code(code),
    .wdata(wdata), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .done(done),
    .acked(acked), .rbyte(rbyte));
  ovw_response ovw_response_i (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
    .cmd_rdata(cmd_rdata), .warn_in(warn_in), .unit_cycles(unit_cycles),
    .clear_status_bit(clear_status_bit), .clear_faults(clear_faults),
    .output_on_cmd(output_on_cmd), .other_fault(other_fault),
    .output_enable(output_enable), .fault_latched(fault_latched), .attempts(attempts));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic wcyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // counts edges until {fault_latched, output_enable} under msk equals want
  task automatic wt(logic [1:0] msk, logic [1:0] want, output int k);
    for (k = 1; k <= 400; k++) begin
      wcyc(1);
      if (({fault_latched, output_enable} & msk) === want) return;
    end
    error_cnt++;
    close_out();
  endtask

  task automatic bus(logic w, logic [7:0] c, logic [7:0] d);
    int i;
    @(posedge sys_clk);
    go <= 1'b1;
    wr <= w;
    code <= c;
    wdata <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wcyc(1);
      if (done === 1'b1) return;
    end
    error_cnt++;
    close_out();
  endtask

  task automatic cfg(logic [1:0] r, logic [2:0] t, logic [2:0] x, logic [15:0] u);
    unit_cycles <= u;
    bus(1'b1, 8'hc4, {r, t, x});
  endtask

  task automatic clr();
    int k;
    clear_faults <= 1'b1;
    wcyc(1);
    clear_faults <= 1'b0;
    wt(2'b11, 2'b01, k);
  endtask

  task automatic t_reg();
    bus(1'b1, 8'hc4, 8'ha5);
    chk("wr_ack", 8'h01, {7'h0, acked});
    bus(1'b1, 8'hc5, 8'h5a);
    chk("bad_ack", 8'h00, {7'h0, acked});
    bus(1'b0, 8'hc4, 8'h00);
    chk("rd_val", 8'ha5, rbyte);
  endtask

  task automatic t_ignore();
    cfg(2'b00, 3'd0, 3'd0, 16'h0001);
    warn_in <= 1'b1;
    wcyc(20);
    chk("ignore", 8'h01, {6'h0, fault_latched, output_enable});
    warn_in <= 1'b0;
  endtask

  // every clearing path, the last one a reset
  task automatic t_latch();
    int k;
    for (int m = 0; m < 4; m++) begin
      cfg(2'b11, 3'd7, 3'd0, 16'h0001);
      warn_in <= 1'b1;
      wt(2'b01, 2'b00, k);
      chk("latch_cyc", 8'd1, k[7:0]);
      warn_in <= 1'b0;
      wcyc(10);
      chk("held_off", 8'h02, {6'h0, fault_latched, output_enable});
      case (m)
        0: clear_status_bit <= 1'b1;
        1: clear_faults <= 1'b1;
        2: output_on_cmd <= 1'b0;
        default: resetn <= 1'b0;
      endcase
      wcyc(2);
      clear_status_bit <= 1'b0;
      clear_faults <= 1'b0;
      output_on_cmd <= 1'b1;
      resetn <= 1'b1;
      wt(2'b11, 2'b01, k);
      chk("cleared", 8'h01, {6'h0, fault_latched, output_enable});
    end
  endtask

  task automatic t_retry(logic [2:0] t, logic [2:0] x, logic [15:0] u);
    int k;
    int iv;
    iv = (1 << x) * u;
    cfg(2'b10, t, x, u);
    warn_in <= 1'b1;
    wt(2'b01, 2'b00, k);
    chk("shut_cyc", 8'd1, k[7:0]);
    wt(2'b10, 2'b10, k);
    if (t != 3'd0) chk("latch_cyc", 8'(t * iv), k[7:0]);
    if (t != 3'd0) chk("att_lim", 8'(t - 3'd1), {5'h0, attempts});
    warn_in <= 1'b0;
    wcyc(2 * iv + 4);
    chk("stay_off", 8'h00, {7'h0, output_enable});
    clr();
    chk("att_clr", 8'h00, {5'h0, attempts});
  endtask

  task automatic t_cont();
    int k;
    cfg(2'b01, 3'd0, 3'd2, 16'h0002);
    warn_in <= 1'b1;
    wt(2'b01, 2'b00, k);
    chk("cont_cyc", 8'd9, k[7:0]);
    wt(2'b10, 2'b10, k);
    warn_in <= 1'b0;
    clr();
    // delay expiry with retries set hands over to the retry wait
    cfg(2'b01, 3'd1, 3'd0, 16'h0002);
    warn_in <= 1'b1;
    wt(2'b01, 2'b00, k);
    chk("cont_shut", 8'd3, k[7:0]);
    wt(2'b10, 2'b10, k);
    chk("cont_latch", 8'd2, k[7:0]);
    warn_in <= 1'b0;
    clr();
    // warning gone before the delay ends keeps the output running
    cfg(2'b01, 3'd0, 3'd3, 16'h0002);
    warn_in <= 1'b1;
    wcyc(4);
    warn_in <= 1'b0;
    wcyc(40);
    chk("cont_clear", 8'h01, {6'h0, fault_latched, output_enable});
  endtask

  task automatic t_ok();
    int k;
    cfg(2'b10, 3'd2, 3'd0, 16'h0004);
    warn_in <= 1'b1;
    wt(2'b01, 2'b00, k);
    warn_in <= 1'b0;
    wt(2'b11, 2'b01, k);
    chk("restart_cyc", 8'd4, k[7:0]);
  endtask

  task automatic t_forever();
    int k;
    // off command in mid retry must drop a nonzero attempt count
    cfg(2'b10, 3'd3, 3'd0, 16'h0002);
    warn_in <= 1'b1;
    wcyc(5);
    chk("att_run", 8'h02, {5'h0, attempts});
    output_on_cmd <= 1'b0;
    warn_in <= 1'b0;
    wcyc(2);
    chk("off_att_run", 8'h00, {5'h0, attempts});
    output_on_cmd <= 1'b1;
    cfg(2'b10, 3'd7, 3'd0, 16'h0002);
    warn_in <= 1'b1;
    wcyc(40);
    chk("forever", 8'h00, {6'h0, fault_latched, output_enable});
    output_on_cmd <= 1'b0;
    wcyc(2);
    chk("off_att", 8'h00, {5'h0, attempts});
    output_on_cmd <= 1'b1;
    other_fault <= 1'b1;
    wt(2'b10, 2'b10, k);
    other_fault <= 1'b0;
    warn_in <= 1'b0;
    clr();
  endtask

  initial begin
    {resetn, go, wr, warn_in, clear_status_bit, clear_faults, other_fault} = 7'h00;
    output_on_cmd = 1'b1;
    {code, wdata} = 16'h0000;
    unit_cycles = 16'h0001;
    repeat (8) @(posedge sys_clk);
    chk("rst_out", 8'h00, {3'h0, fault_latched, output_enable, attempts});
    chk("rst_reg", 8'h00, cmd_rdata);
    resetn <= 1'b1;
    t_reg();
    t_ignore();
    t_latch();
    t_retry(3'd0, 3'd0, 16'h0002);
    t_retry(3'd3, 3'd1, 16'h0003);
    t_retry(3'd1, 3'd7, 16'h0001);
    t_cont();
    t_ok();
    t_forever();
    close_out();
  end
endmodule
